// >>> design/chsc_pkg.sv
`default_nettype none
package chsc_pkg;
  // register indices
  localparam logic [7:0] ADDR_IDENTITY = 8'h00;
  localparam logic [7:0] ADDR_MASK1 = 8'h01;
  localparam logic [7:0] ADDR_MASK2 = 8'h02;
  localparam logic [7:0] ADDR_FLAGS1 = 8'h03;
  localparam logic [7:0] ADDR_FLAGS2 = 8'h04;
  localparam logic [7:0] ADDR_EN1 = 8'h05;
  localparam logic [7:0] ADDR_CONTROL = 8'h06;
  localparam logic [7:0] ADDR_CONVERTER = 8'h07;
  localparam logic [7:0] ADDR_CONV_EN = 8'h08;
  localparam logic [7:0] ADDR_BUS_THR = 8'h11;
  localparam logic [7:0] ADDR_BAT_THR = 8'h12;
  localparam logic [7:0] ADDR_FLAGS3 = 8'h26;
  localparam logic [7:0] ADDR_LAST_LOW = 8'h29;
  localparam logic [7:0] ADDR_HIGH = 8'h40;
  localparam logic [7:0] ADDR_MULTI_LAST = 8'h08;
  localparam logic [7:0] UNMAPPED_VALUE = 8'hff;
  // field positions
  localparam int BIT_SOFT_RESET = 0;
  localparam int BIT_WDOG_LO = 2;
  localparam int BIT_WDOG_HI = 3;
  localparam int BIT_CHARGE_EN = 4;
  localparam int BIT_CONV_EN = 3;
  localparam int BIT_BUS_OTP = 0;
  localparam int BIT_BAT_OTP = 1;
  localparam int BIT_BUS_CONV_CH = 0;
  // reset values
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_EN1 = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h0c;
  localparam logic [7:0] RST_CONVERTER = 8'h00;
  localparam logic [7:0] RST_CONV_EN = 8'h00;
  localparam logic [7:0] RST_THR = 8'h00;
  localparam logic [7:0] RST_GENERIC = 8'h00;
  localparam logic [7:0] THR_MAX_CODE = 8'h07;
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int DEGLITCH_US = 10;
  localparam int DEGLITCH_CYC = (DEGLITCH_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
    DEGLITCH_US * (CLK_HZ / 1_000_000);
  localparam int WDOG_MS = 40;
  localparam int WDOG_CYC = WDOG_MS * (CLK_HZ / 1000);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX,
    ST_TX_ACK} chsc_state_t;
endpackage
`default_nettype wire

// >>> design/chsc_top.sv
// Contract
// - falling thermistor input past threshold raises over-temperature fault
// - after deglitch, switch off, charge enable cleared until host rewrites it
// - threshold writes above largest code store largest code
// - fault flag latches threshold crossing until read
// - unmasked set flag drives active-low alert; mask one suppresses
// - connector fault suppressed while connector converter channel enabled
// - slave only, 7-bit address chosen by address-select pin
// - registers 0x00-0x29 and 0x40; other reads return 0xff
// - serial port works up to 1 Mbit/s
// - sda changed only while scl low
// - bytes 8 bits, msb first, each followed by acknowledge
// - slave may hold scl low between bytes; this slave never does, o_scl_oe_n is tied high
// - transmitter releases sda on ninth pulse; receiver pulls low
// - address byte then direction bit, zero write, one read
// - undefined register address gets not-acknowledge and idle
// - multi-byte access across consecutive registers 0x00-0x08
// - event flags latch until read, then show present state
// - reset and control bit 0 return all registers to defaults
// - watchdog expiry restores charge enable and converter enable
// - data byte writes and reads restart watchdog; control bits 3:2 zero disable it
`default_nettype none
module chsc_top
  import chsc_pkg::*;
#(
  parameter int WDOG_CYCLES = chsc_pkg::WDOG_CYC,
  parameter logic [6:0] BASE_ADDR = 7'h6a,
  parameter logic [7:0] IDENTITY = 8'h5a
)(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  output logic o_scl,
  output logic o_scl_oe_n,
  input wire logic i_addr_sel,
  input wire logic i_connector_hot,
  input wire logic i_battery_hot,
  output logic o_alert_n,
  output logic o_charge_switch_on,
  output logic o_converter_enable
);
  import chsc_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [2:0] scl_s, sda_s, bus_s, bat_s, asel_s;
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      bus_s <= 3'h7;
      bat_s <= 3'h7;
      asel_s <= 3'h0;
    end
    else
    begin
      scl_s <= {scl_s[1:0], i_scl};
      sda_s <= {sda_s[1:0], i_sda};
      bus_s <= {bus_s[1:0], ~i_connector_hot};
      bat_s <= {bat_s[1:0], ~i_battery_hot};
      asel_s <= {asel_s[1:0], i_addr_sel};
    end
  end
  logic scl, sda, scl_q, sda_q, asel;
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      scl <= 1'b1;
      sda <= 1'b1;
      asel <= 1'b0;
    end
    else
    begin
      // filter latency is far below a 1 Mbit/s half period
      if (scl_s[1] == scl_s[2]) scl <= scl_s[2];
      if (sda_s[1] == sda_s[2]) sda <= sda_s[2];
      if (asel_s[1] == asel_s[2]) asel <= asel_s[2];
    end
  end
  always_ff @(posedge i_clk)
  begin
    scl_q <= i_srst ? 1'b1 : scl;
    sda_q <= i_srst ? 1'b1 : sda;
  end
  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  // master-made conditions
  wire start_c = scl & scl_q & sda_q & ~sda;
  wire stop_c = scl & scl_q & ~sda_q & sda;
  wire [6:0] my_addr = {BASE_ADDR[6:1], asel};

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] mask1, mask2, en1, control, converter, conv_en, bus_thr, bat_thr;
  logic [7:0] flags1, flags2;
  logic [7:0] ptr, rd_data;
  logic wr_stb, rd_stb, access_stb;
  logic [7:0] wr_data;
  logic wdog_expire, bus_fault, bat_fault;
  wire soft_rst = wr_stb && ptr == ADDR_CONTROL && wr_data[BIT_SOFT_RESET];
  wire clr_all = i_srst | soft_rst;
  function automatic logic [7:0] clamp_thr(input logic [7:0] v);
    clamp_thr = (v > THR_MAX_CODE) ? THR_MAX_CODE : v;
  endfunction
  always_ff @(posedge i_clk)
  begin
    if (clr_all)
    begin
      mask1 <= RST_MASK;
      mask2 <= RST_MASK;
      en1 <= RST_EN1;
      conv_en <= RST_CONV_EN;
      bus_thr <= RST_THR;
      bat_thr <= RST_THR;
    end
    else if (wr_stb)
    begin
      case (ptr)
        ADDR_MASK1: mask1 <= wr_data;
        ADDR_MASK2: mask2 <= wr_data;
        ADDR_EN1: en1 <= wr_data;
        ADDR_CONV_EN: conv_en <= wr_data;
        ADDR_BUS_THR: bus_thr <= clamp_thr(wr_data);
        ADDR_BAT_THR: bat_thr <= clamp_thr(wr_data);
        default: ;
      endcase
    end
  end
  // control and converter: faults and watchdog override
  always_ff @(posedge i_clk)
  begin
    if (clr_all)
    begin
      control <= RST_CONTROL;
      converter <= RST_CONVERTER;
    end
    else
    begin
      if (wr_stb && ptr == ADDR_CONTROL)
        control <= wr_data;
      if (wr_stb && ptr == ADDR_CONVERTER)
        converter <= wr_data;
      if (bus_fault | bat_fault)
        control[BIT_CHARGE_EN] <= 1'b0;
      if (wdog_expire)
      begin
        control[BIT_CHARGE_EN] <= RST_CONTROL[BIT_CHARGE_EN];
        converter[BIT_CONV_EN] <= RST_CONVERTER[BIT_CONV_EN];
      end
    end
  end
  assign o_charge_switch_on = control[BIT_CHARGE_EN];
  assign o_converter_enable = converter[BIT_CONV_EN];

  // ----------------------------------------
  // over-temperature deglitch
  // ----------------------------------------
  wire bus_hot_raw = (bus_s[1] == bus_s[2]) & ~bus_s[2] & ~conv_en[BIT_BUS_CONV_CH];
  wire bat_hot_raw = (bat_s[1] == bat_s[2]) & ~bat_s[2];
  logic [$clog2(DEGLITCH_CYC+1)-1:0] bus_cnt, bat_cnt;
  localparam logic [$clog2(DEGLITCH_CYC+1)-1:0] DG = DEGLITCH_CYC[$clog2(DEGLITCH_CYC+1)-1:0];
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      bus_cnt <= '0;
      bat_cnt <= '0;
    end
    else
    begin
      bus_cnt <= !bus_hot_raw ? '0 : (bus_cnt == DG ? DG : bus_cnt + 1'b1);
      bat_cnt <= !bat_hot_raw ? '0 : (bat_cnt == DG ? DG : bat_cnt + 1'b1);
    end
  end
  assign bus_fault = bus_cnt == DG;
  assign bat_fault = bat_cnt == DG;
  // latched event flags
  wire [7:0] live1 = {6'h0, bat_fault, bus_fault};
  wire rd_f1 = rd_stb && ptr == ADDR_FLAGS1;
  wire rd_f2 = rd_stb && ptr == ADDR_FLAGS2;
  always_ff @(posedge i_clk)
  begin
    if (clr_all)
    begin
      flags1 <= RST_GENERIC;
      flags2 <= RST_GENERIC;
    end
    else
    begin
      // read reloads present state; new events still land
      flags1 <= (rd_f1 ? 8'h00 : flags1) | live1;
      flags2 <= rd_f2 ? 8'h00 : flags2;
    end
  end
  assign o_alert_n = ~(|(flags1 & ~mask1) | |(flags2 & ~mask2));

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  logic [$clog2(WDOG_CYCLES+1)-1:0] wdog_cnt;
  wire wdog_on = |control[BIT_WDOG_HI:BIT_WDOG_LO];
  always_ff @(posedge i_clk)
  begin
    if (i_srst || !wdog_on || access_stb)
      wdog_cnt <= '0;
    else if (wdog_cnt == WDOG_CYCLES[$clog2(WDOG_CYCLES+1)-1:0])
      wdog_cnt <= '0;
    else
      wdog_cnt <= wdog_cnt + 1'b1;
  end
  assign wdog_expire = wdog_on && !access_stb &&
    wdog_cnt == WDOG_CYCLES[$clog2(WDOG_CYCLES+1)-1:0];

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire defined = ptr <= ADDR_LAST_LOW || ptr == ADDR_HIGH;
  always_comb
  begin
    case (ptr)
      ADDR_IDENTITY: rd_data = IDENTITY; // value arbitrary
      ADDR_MASK1: rd_data = mask1;
      ADDR_MASK2: rd_data = mask2;
      ADDR_FLAGS1: rd_data = flags1;
      ADDR_FLAGS2: rd_data = flags2;
      ADDR_EN1: rd_data = en1;
      ADDR_CONTROL: rd_data = control;
      ADDR_CONVERTER: rd_data = converter;
      ADDR_CONV_EN: rd_data = conv_en;
      ADDR_BUS_THR: rd_data = bus_thr;
      ADDR_BAT_THR: rd_data = bat_thr;
      default: rd_data = defined ? RST_GENERIC : UNMAPPED_VALUE;
    endcase
  end

  // ----------------------------------------
  // serial slave
  // ----------------------------------------
  chsc_state_t st;
  logic [7:0] sh;
  logic [3:0] bitn;
  logic is_read, have_ptr, ack_ok, sda_low;
  wire [7:0] next_sh = {sh[6:0], sda};
  always_ff @(posedge i_clk)
  begin
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    access_stb <= 1'b0;
    if (i_srst || stop_c)
    begin
      st <= ST_IDLE;
      sda_low <= 1'b0;
      bitn <= '0;
      is_read <= 1'b0;
      have_ptr <= 1'b0;
      ack_ok <= 1'b0;
      sh <= '0;
      wr_data <= '0;
      if (i_srst) ptr <= '0;
    end
    else if (start_c)
    begin
      st <= ST_ADDR;
      bitn <= '0;
      sda_low <= 1'b0;
      have_ptr <= 1'b0;
    end
    else
    begin
      case (st)
        ST_IDLE: sda_low <= 1'b0;
        ST_ADDR, ST_RX:
          if (scl_rise)
          begin
            sh <= next_sh;
            bitn <= bitn + 1'b1;
          end
          else if (scl_fall && bitn == 4'd8)
          begin
            bitn <= '0;
            st <= (st == ST_ADDR) ? ST_ADDR_ACK : ST_RX_ACK;
            if (st == ST_ADDR)
            begin
              ack_ok <= sh[7:1] == my_addr;
              sda_low <= sh[7:1] == my_addr;
              is_read <= sh[0];
            end
            else if (!have_ptr)
            begin
              ack_ok <= next_ptr_ok(sh);
              sda_low <= next_ptr_ok(sh);
            end
            else
            begin
              ack_ok <= 1'b1;
              sda_low <= 1'b1;
              wr_data <= sh;
              wr_stb <= defined;
              access_stb <= 1'b1;
            end
          end
        ST_ADDR_ACK, ST_RX_ACK:
          if (scl_fall)
          begin // sda changes on scl low only
            if (!ack_ok)
            begin
              st <= ST_IDLE;
              sda_low <= 1'b0;
            end
            else if (st == ST_ADDR_ACK && is_read)
            begin
              st <= ST_TX;
              sh <= rd_data;
              sda_low <= ~rd_data[7];
              rd_stb <= 1'b1;
              access_stb <= 1'b1;
            end
            else
            begin
              st <= ST_RX;
              sda_low <= 1'b0;
              if (st == ST_RX_ACK && !have_ptr)
              begin
                ptr <= sh;
                have_ptr <= 1'b1;
              end
              else if (st == ST_RX_ACK && ptr < ADDR_MULTI_LAST)
                ptr <= ptr + 1'b1;
            end
          end
        ST_TX:
          if (scl_fall)
          begin
            bitn <= bitn + 1'b1;
            if (bitn == 4'd7)
            begin
              st <= ST_TX_ACK;
              sda_low <= 1'b0;
            end
            else
            begin
              sh <= {sh[6:0], 1'b0};
              sda_low <= ~sh[6];
            end
          end
        ST_TX_ACK:
          if (scl_rise)
          begin
            ack_ok <= ~sda;
            if (~sda && ptr < ADDR_MULTI_LAST) ptr <= ptr + 1'b1;
          end
          else if (scl_fall)
          begin
            bitn <= '0;
            if (!ack_ok)
              st <= ST_IDLE;
            else
            begin
              st <= ST_TX;
              sh <= rd_data;
              sda_low <= ~rd_data[7];
              rd_stb <= 1'b1;
              access_stb <= 1'b1;
            end
          end
        default: st <= ST_IDLE;
      endcase
    end
  end
  function automatic logic next_ptr_ok(input logic [7:0] p);
    next_ptr_ok = p <= ADDR_LAST_LOW || p == ADDR_HIGH;
  endfunction
  // pointer moves on the ack high phase, so the next byte loads at its fall
  assign o_sda = 1'b0;
  assign o_sda_oe_n = ~sda_low;
  // no stretching needed at this clock rate
  assign o_scl = 1'b0;
  assign o_scl_oe_n = 1'b1;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_alert_follow: assert property (@(posedge i_clk) disable iff (i_srst)
    (|(flags1 & ~mask1)) |-> !o_alert_n) else $error("alert not asserted");
  chk_mask_quiet: assert property (@(posedge i_clk) disable iff (i_srst)
    (flags1 & ~mask1) == 8'h0 && flags2 == 8'h0 |-> o_alert_n)
    else $error("alert while masked");
  chk_fault_offswitch: assert property (@(posedge i_clk) disable iff (i_srst)
    bus_fault && !wdog_expire |=> !o_charge_switch_on) else $error("switch left on");
  chk_fault_flagset: assert property (@(posedge i_clk) disable iff (i_srst)
    bat_fault && !soft_rst |=> flags1[BIT_BAT_OTP]) else $error("flag missed");
  chk_conv_blocks: assert property (@(posedge i_clk) disable iff (i_srst)
    conv_en[BIT_BUS_CONV_CH] |-> !bus_fault) else $error("bus fault while converting");
  chk_thr_clamp: assert property (@(posedge i_clk) disable iff (i_srst)
    bus_thr <= THR_MAX_CODE && bat_thr <= THR_MAX_CODE) else $error("threshold above max");
  chk_soft_reset: assert property (@(posedge i_clk) disable iff (i_srst)
    soft_rst |=> control == RST_CONTROL && mask1 == RST_MASK)
    else $error("soft reset failed");
  chk_wdog_clear: assert property (@(posedge i_clk) disable iff (i_srst)
    wdog_expire && !soft_rst |=> !converter[BIT_CONV_EN]) else $error("watchdog no clear");
  chk_sda_scl_low: assert property (@(posedge i_clk) disable iff (i_srst)
    scl && scl_q && !start_c && !stop_c && st != ST_IDLE |=> $stable(sda_low) || stop_c
    || start_c) else $error("sda moved with scl high");
  chk_ptr_range: assert property (@(posedge i_clk) disable iff (i_srst)
    st == ST_TX_ACK && scl_fall && ack_ok && ptr == ADDR_MULTI_LAST |=> ptr == ADDR_MULTI_LAST)
    else $error("pointer ran past multi range");
  cov_write: cover property (@(posedge i_clk) wr_stb);
  cov_read: cover property (@(posedge i_clk) rd_stb);
  cov_fault: cover property (@(posedge i_clk) bus_fault && !o_alert_n);
endmodule
`default_nettype wire

// >>> bench/chsc_host_model.sv
`default_nettype none
module chsc_host_model
(
  input wire logic i_clk,
  input wire logic i_dev_sda,
  input wire logic i_dev_sda_oe_n,
  input wire logic i_dev_scl,
  input wire logic i_dev_scl_oe_n,
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // ------------------------------------------------------------
  // open-drain lines with pull-up
  // ------------------------------------------------------------
  assign o_scl = !(scl_low || (!i_dev_scl_oe_n && !i_dev_scl));
  assign o_sda = !(sda_low || (!i_dev_sda_oe_n && !i_dev_sda));
  // ------------------------------------------------------------
  // bit, byte and frame tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // one clock pulse, data set mid-low, sampled at end of high
  task automatic bit_xfer(input logic d, output logic q);
    int w;
    tick(3);
    sda_low <= !d;
    tick(3);
    scl_low <= 1'b0;
    w = 0;
    do
    begin
      tick(1);
      w++;
    end while (!o_scl && w < 64);
    tick(1);
    q = o_sda;
    scl_low <= 1'b1;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--)
      bit_xfer(b[i], q);
    bit_xfer(1'b1, q);
    ack = !q;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--)
      bit_xfer(1'b1, b[i]);
    bit_xfer(last, q);
  endtask
  task automatic start();
    tick(3);
    sda_low <= 1'b0;
    tick(3);
    scl_low <= 1'b0;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl_low <= 1'b1;
  endtask
  task automatic stop();
    tick(3);
    sda_low <= 1'b1;
    tick(3);
    scl_low <= 1'b0;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask
  // acks: address, pointer, then data bytes
  task automatic write_regs(input logic [6:0] dev, input logic [7:0] ptr, input int n,
      input logic [15:0] d, input logic hold, output logic [3:0] acks);
    acks = 4'h0;
    start();
    send_byte({dev, 1'b0}, acks[0]);
    if (acks[0])
      send_byte(ptr, acks[1]);
    for (int i = 0; i < n && acks[1]; i++)
      send_byte(d[15-8*i -: 8], acks[2+i]);
    if (!hold)
      stop();
  endtask
  task automatic read_regs(input logic [6:0] dev, input logic [7:0] ptr, input int n,
      output logic [15:0] r, output logic ok);
    logic [3:0] acks;
    logic a;
    write_regs(dev, ptr, 0, 16'h0000, 1'b1, acks);
    start();
    send_byte({dev, 1'b1}, a);
    r = 16'h0000;
    for (int i = 0; i < n && a; i++)
      get_byte(i == n - 1, r[15-8*i -: 8]);
    stop();
    ok = acks[1] && a;
  endtask
endmodule
`default_nettype wire

// >>> bench/charger_host_serial_control_bench.sv
`default_nettype none
module charger_host_serial_control_bench;
  import chsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHECK(nm, e, g) \
    begin \
      samples_checked++; \
      if ((g) !== (e)) \
      begin \
        bad_count++; \
        $display("unexpected %s: expected %h, seen %h", nm, e, g); \
      end \
    end
  localparam int WDOG = 3000;
  localparam int DG = DEGLITCH_CYC + 20;
  localparam logic [6:0] DEV = 7'h6a;
  localparam logic [7:0] IDENT = 8'h5a;  // arbitrary value
  typedef struct packed {logic [7:0] p; logic [7:0] d; logic [7:0] e;} chsc_row_t;
  chsc_row_t rows [6] = '{'{ADDR_MASK1, 8'ha5, 8'ha5}, '{ADDR_MASK2, 8'h3c, 8'h3c},
    '{ADDR_EN1, 8'hff, 8'hff}, '{ADDR_IDENTITY, 8'h12, IDENT},
    '{ADDR_BUS_THR, 8'h09, THR_MAX_CODE}, '{ADDR_BAT_THR, 8'h05, 8'h05}};
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic addr_sel = 1'b0;
  logic conn_hot = 1'b0;
  logic bat_hot = 1'b0;
  logic scl, sda, dev_sda, dev_sda_oe_n, dev_scl, dev_scl_oe_n;
  logic alert_n, chg_on, conv_on, ok;
  logic [3:0] a;
  logic [15:0] r;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #12.5 i_clk = ~i_clk;
  chsc_top #(.WDOG_CYCLES(WDOG), .BASE_ADDR(DEV), .IDENTITY(IDENT)) DUT (
    .i_clk(i_clk), .i_srst(i_srst), .i_scl(scl), .i_sda(sda),
    .o_sda(dev_sda), .o_sda_oe_n(dev_sda_oe_n), .o_scl(dev_scl),
    .o_scl_oe_n(dev_scl_oe_n), .i_addr_sel(addr_sel), .i_connector_hot(conn_hot),
    .i_battery_hot(bat_hot), .o_alert_n(alert_n), .o_charge_switch_on(chg_on),
    .o_converter_enable(conv_on));
  chsc_host_model host (
    .i_clk(i_clk), .i_dev_sda(dev_sda), .i_dev_sda_oe_n(dev_sda_oe_n),
    .i_dev_scl(dev_scl), .i_dev_scl_oe_n(dev_scl_oe_n), .o_scl(scl), .o_sda(sda));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [3:0] k;
    host.write_regs(DEV, p, 1, {d, 8'h00}, 1'b0, k);
    `CHECK("write acks", 4'h7, k)
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] p, input logic [7:0] e);
    logic [15:0] q;
    logic g;
    host.read_regs(DEV, p, 1, q, g);
    `CHECK(nm, {1'b1, e}, {g, q[15:8]})
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    idle(3);
    i_srst <= 1'b0;
    idle(6);
    `CHECK("alert", 1'b1, alert_n)
    `CHECK("charge", 1'b0, chg_on)
    rd_chk("control", ADDR_CONTROL, RST_CONTROL);
    rd_chk("mask1", ADDR_MASK1, RST_MASK);
    foreach (rows[i])
    begin
      wr(rows[i].p, rows[i].d);
      rd_chk("row", rows[i].p, rows[i].e);
    end
    // address select and refusals
    host.write_regs(7'h6b, ADDR_MASK1, 0, 16'h0000, 1'b0, a);
    `CHECK("other addr", 4'h0, a)
    addr_sel <= 1'b1;
    idle(4);
    host.write_regs(7'h6b, ADDR_MASK1, 0, 16'h0000, 1'b0, a);
    `CHECK("sel addr", 4'h3, a)
    addr_sel <= 1'b0;
    idle(4);
    host.write_regs(DEV, 8'h2a, 0, 16'h0000, 1'b0, a);
    `CHECK("bad ptr", 4'h1, a)
    host.read_regs(DEV, ADDR_HIGH, 1, r, ok);
    `CHECK("high reg", 1'b1, ok)
    // multi-byte access
    host.write_regs(DEV, ADDR_MASK1, 2, 16'h1122, 1'b0, a);
    `CHECK("multi acks", 4'hf, a)
    host.read_regs(DEV, ADDR_MASK1, 2, r, ok);
    `CHECK("multi read", {1'b1, 16'h1122}, {ok, r})
    // battery over-temperature
    wr(ADDR_MASK1, 8'h00);
    wr(ADDR_CONTROL, 8'h1c);
    `CHECK("charge on", 1'b1, chg_on)
    bat_hot <= 1'b1;
    idle(DG);
    `CHECK("charge off", 1'b0, chg_on)
    `CHECK("alert set", 1'b0, alert_n)
    rd_chk("flags hot", ADDR_FLAGS1, 8'h02);
    bat_hot <= 1'b0;
    idle(DG);
    rd_chk("flags held", ADDR_FLAGS1, 8'h02);
    rd_chk("flags now", ADDR_FLAGS1, 8'h00);
    `CHECK("alert clear", 1'b1, alert_n)
    `CHECK("still off", 1'b0, chg_on)
    rd_chk("control", ADDR_CONTROL, 8'h0c);
    wr(ADDR_MASK1, 8'h02);
    bat_hot <= 1'b1;
    idle(DG);
    `CHECK("masked", 1'b1, alert_n)
    bat_hot <= 1'b0;
    idle(DG);
    rd_chk("flags held", ADDR_FLAGS1, 8'h02);
    rd_chk("flags now", ADDR_FLAGS1, 8'h00);
    // connector over-temperature
    wr(ADDR_CONV_EN, 8'h01);
    conn_hot <= 1'b1;
    idle(DG);
    rd_chk("conn measured", ADDR_FLAGS1, 8'h00);
    wr(ADDR_CONV_EN, 8'h00);
    idle(DG);
    rd_chk("conn hot", ADDR_FLAGS1, 8'h01);
    `CHECK("conn alert", 1'b0, alert_n)
    conn_hot <= 1'b0;
    idle(DG);
    rd_chk("conn held", ADDR_FLAGS1, 8'h01);
    rd_chk("conn now", ADDR_FLAGS1, 8'h00);
    // watchdog
    wr(ADDR_CONTROL, 8'h1c);
    wr(ADDR_CONVERTER, 8'h08);
    `CHECK("conv on", 1'b1, conv_on)
    idle(WDOG / 2);
    rd_chk("converter", ADDR_CONVERTER, 8'h08);
    idle(WDOG * 3 / 4);
    `CHECK("kept alive", 1'b1, chg_on)
    idle(WDOG / 2);
    `CHECK("wdog charge", 1'b0, chg_on)
    `CHECK("wdog conv", 1'b0, conv_on)
    wr(ADDR_CONTROL, 8'h10);
    idle(WDOG + 100);
    `CHECK("wdog off", 1'b1, chg_on)
    // soft reset
    wr(ADDR_CONTROL, 8'h01);
    rd_chk("mask after", ADDR_MASK1, RST_MASK);
    rd_chk("control after", ADDR_CONTROL, RST_CONTROL);
    `CHECK("charge after", 1'b0, chg_on)
    give_verdict();
  end
endmodule
`default_nettype wire
